// [verilog/tpg_consts.svh]
`ifndef TPG_CONSTS_SVH
`define TPG_CONSTS_SVH

// Register indices; byte address is four times the index.
`define TPG_IDX_ON 3'h0
`define TPG_IDX_SEL 3'h1
`define TPG_IDX_INJ 3'h2
`define TPG_IDX_LEAD 3'h3
`define TPG_IDX_CLO 3'h4
`define TPG_IDX_CHI 3'h5
`define TPG_IDX_LAST 3'h5

// Byte address bits that select a word.
`define TPG_ADDR_W 5
`define TPG_IDX_LSB 2

// Field positions.
`define TPG_ON_BIT 0
`define TPG_INJ_BIT 0
`define TPG_LEAD_EN_BIT 0
`define TPG_BEATS_MSB 15
`define TPG_BEATS_LSB 8
`define TPG_SEL_P7 0
`define TPG_SEL_P15 1
`define TPG_SEL_P23 2
`define TPG_SEL_P31 3
`define TPG_SEL_HF 4
`define TPG_SEL_LF 5
`define TPG_SEL_W 6
`define TPG_CHI_W 8

// Reset values.
`define TPG_SEL_RST 6'h01
`define TPG_BEATS_RST 8'h00
`define TPG_CLO_RST 32'h00000000
`define TPG_CHI_RST 8'h00

// Shift register lengths and second feedback taps.
`define TPG_P7_LEN 7
`define TPG_P7_TAP 6
`define TPG_P15_LEN 15
`define TPG_P15_TAP 14
`define TPG_P23_LEN 23
`define TPG_P23_TAP 18
`define TPG_P31_LEN 31
`define TPG_P31_TAP 28

`endif

// [verilog/tpg_pkg.sv]
package tpg_pkg;

  typedef enum logic [1:0] {
    TPG_IDLE = 2'b00,
    TPG_LEAD = 2'b01,
    TPG_RUN = 2'b10
  } tpg_phase_t;

endpackage : tpg_pkg

// [verilog/tpg_prbs.sv]
`timescale 1ns/1ps
`default_nettype none

module tpg_prbs #(
  parameter int LEN = 7,
  parameter int TAP = 6,
  parameter int WIDTH = 40
) (
  // Current and advanced shift register.
  input wire logic [LEN-1:0] state,
  output logic [LEN-1:0] next_state,
  // Bits of one beat, first bit in the top position.
  output logic [WIDTH-1:0] bits
);

  logic [LEN-1:0] s;
  logic fb;

  if (LEN < 2 || TAP < 1 || TAP >= LEN)
  begin : g_bad
    $error("tpg_prbs: tap must lie below the register length.");
  end

  always_comb
  begin
    s = state;
    fb = 1'b0;
    bits = '0;
    for (int i = 0; i < WIDTH; i++)
    begin
      fb = s[LEN-1] ^ s[TAP-1];
      bits[WIDTH-1-i] = fb;
      s = {s[LEN-2:0], fb};
    end
    next_state = s;
  end

endmodule : tpg_prbs

`default_nettype wire

// [verilog/tpg_top.sv]
// Notes on behaviour
// [RULE_01] Generate only while on/off bit 0 is set.
// [RULE_02] While on, only on/off and error writes apply.
// [RULE_03] Final output held on the next cycle after off.
// [RULE_04] Select bit 0 gives PRBS-7, taps 7 and 6.
// [RULE_05] Select bit 1 gives PRBS-15, taps 15 and 14.
// [RULE_06] Select bit 2 gives PRBS-23, taps 23 and 18.
// [RULE_07] Select bit 3 gives PRBS-31, taps 31 and 28.
// [RULE_08] Select bit 4 gives alternating 0101 symbols.
// [RULE_09] Select bit 5 gives half ones, half zeros.
// [RULE_10] Software keeps the select field one-hot.
// [RULE_11] Error request flips exactly one stream bit.
// [RULE_12] Error request stays set until applied.
// [RULE_13] Repeat request while pending does nothing.
// [RULE_14] Corrupted beat may vanish if switched off.
// [RULE_15] Lead-in character sent first when enabled.
// [RULE_16] Lead-in control bits 15:8 give beat count.
// [RULE_17] Low lead-in register gives character bits 31:0.
// [RULE_18] High register gives bits 39:32, unused at 32.
// [RULE_19] Software writes zeros to reserved fields.
// [RULE_20] One beat per clock while generating.
//
// The address map and the APB register port were decided locally.
`include "tpg_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module tpg_top
  import tpg_pkg::*;
#(
  parameter int stream_width_param = 40
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_b,
  // APB slave.
  input wire logic [`TPG_ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Stream source.
  output logic [stream_width_param-1:0] stream_data,
  output logic stream_valid
);

  localparam int SYM_W = stream_width_param / 4;

  if (stream_width_param != 32 && stream_width_param != 40)
  begin : g_bad_width
    $error("tpg_top: stream width must be 32 or 40.");
  end

  // Register state.
  tpg_phase_t phase_q;
  logic [`TPG_SEL_W-1:0] sel_q;
  logic inject_q;
  logic lead_en_q;
  logic [7:0] beats_q;
  logic [31:0] char_lo_q;
  logic [`TPG_CHI_W-1:0] char_hi_q;
  logic [7:0] lead_cnt_q;

  // Bus slave state.
  logic pready_q;
  logic pslverr_q;
  logic [31:0] prdata_q;

  // Stream state.
  logic [stream_width_param-1:0] data_q;
  logic valid_q;

  // Shift registers, one per sequence length.
  logic [`TPG_P7_LEN-1:0] p7_q;
  logic [`TPG_P15_LEN-1:0] p15_q;
  logic [`TPG_P23_LEN-1:0] p23_q;
  logic [`TPG_P31_LEN-1:0] p31_q;
  logic [`TPG_P7_LEN-1:0] p7_d;
  logic [`TPG_P15_LEN-1:0] p15_d;
  logic [`TPG_P23_LEN-1:0] p23_d;
  logic [`TPG_P31_LEN-1:0] p31_d;
  logic [stream_width_param-1:0] p7_bits;
  logic [stream_width_param-1:0] p15_bits;
  logic [stream_width_param-1:0] p23_bits;
  logic [stream_width_param-1:0] p31_bits;

  // Decode.
  logic [2:0] idx;
  logic mapped;
  logic take;
  logic wr;
  logic cfg_wr;
  logic gen_on;
  logic start;
  logic stop;
  logic apply;
  logic [31:0] rd_d;
  logic [stream_width_param-1:0] hf_word;
  logic [stream_width_param-1:0] lf_word;
  logic [stream_width_param-1:0] lead_char;
  logic [39:0] char_full;
  logic [stream_width_param-1:0] pat_d;
  logic [stream_width_param-1:0] beat_d;
  logic [stream_width_param-1:0] flip;

  assign idx = paddr[`TPG_IDX_LSB+2:`TPG_IDX_LSB];
  assign mapped = (idx <= `TPG_IDX_LAST);
  assign take = psel & penable & pready_q;
  assign wr = take & pwrite & mapped;
  // Configuration is frozen while the generator runs.
  assign cfg_wr = wr & ~gen_on; // [RULE_02]
  assign gen_on = (phase_q != TPG_IDLE); // [RULE_01]
  assign start = wr & (idx == `TPG_IDX_ON) & pwdata[`TPG_ON_BIT] & ~gen_on;
  assign stop = wr & (idx == `TPG_IDX_ON) & ~pwdata[`TPG_ON_BIT];
  assign apply = inject_q & gen_on; // [RULE_11]

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign stream_data = data_q;
  assign stream_valid = valid_q;

  tpg_prbs #(
    .LEN(`TPG_P7_LEN),
    .TAP(`TPG_P7_TAP),
    .WIDTH(stream_width_param)
  ) u_p7 (
    .state(p7_q),
    .next_state(p7_d),
    .bits(p7_bits)
  ); // [RULE_04]

  tpg_prbs #(
    .LEN(`TPG_P15_LEN),
    .TAP(`TPG_P15_TAP),
    .WIDTH(stream_width_param)
  ) u_p15 (
    .state(p15_q),
    .next_state(p15_d),
    .bits(p15_bits)
  ); // [RULE_05]

  tpg_prbs #(
    .LEN(`TPG_P23_LEN),
    .TAP(`TPG_P23_TAP),
    .WIDTH(stream_width_param)
  ) u_p23 (
    .state(p23_q),
    .next_state(p23_d),
    .bits(p23_bits)
  ); // [RULE_06]

  tpg_prbs #(
    .LEN(`TPG_P31_LEN),
    .TAP(`TPG_P31_TAP),
    .WIDTH(stream_width_param)
  ) u_p31 (
    .state(p31_q),
    .next_state(p31_d),
    .bits(p31_bits)
  ); // [RULE_07]

  // Fixed patterns and the lead-in character.
  always_comb
  begin
    hf_word = '0;
    lf_word = '0;
    for (int s = 0; s < 4; s++)
    begin
      hf_word[s*SYM_W +: SYM_W] = {(SYM_W/2){2'b01}}; // [RULE_08]
      lf_word[s*SYM_W +: SYM_W] =
        {{(SYM_W/2){1'b1}}, {(SYM_W/2){1'b0}}}; // [RULE_09]
    end
  end

  // The top byte drops out of a 32-bit stream.
  assign char_full = {char_hi_q, char_lo_q}; // [RULE_17]
  assign lead_char = char_full[stream_width_param-1:0]; // [RULE_18]

  // Lowest set select bit wins; other mixes are left to software.
  always_comb
  begin
    pat_d = hf_word;
    if (sel_q[`TPG_SEL_P7])
      pat_d = p7_bits;
    else if (sel_q[`TPG_SEL_P15])
      pat_d = p15_bits;
    else if (sel_q[`TPG_SEL_P23])
      pat_d = p23_bits;
    else if (sel_q[`TPG_SEL_P31])
      pat_d = p31_bits;
    else if (sel_q[`TPG_SEL_HF])
      pat_d = hf_word;
    else if (sel_q[`TPG_SEL_LF])
      pat_d = lf_word;
  end

  always_comb
  begin
    case (phase_q)
      TPG_LEAD: beat_d = lead_char; // [RULE_15]
      TPG_RUN: beat_d = pat_d;
      default: beat_d = data_q;
    endcase
    flip = '0;
    flip[0] = apply; // [RULE_11]
  end

  // Phase of generation.
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      phase_q <= TPG_IDLE;
      lead_cnt_q <= 8'h00;
    end
    else
    begin
      case (phase_q)
        TPG_IDLE:
        begin
          if (start && lead_en_q && beats_q != 8'h00)
          begin
            phase_q <= TPG_LEAD; // [RULE_15]
            lead_cnt_q <= beats_q; // [RULE_16]
          end
          else if (start)
            phase_q <= TPG_RUN;
        end
        TPG_LEAD:
        begin
          lead_cnt_q <= lead_cnt_q - 8'h01;
          if (stop)
            phase_q <= TPG_IDLE; // [RULE_01]
          else if (lead_cnt_q == 8'h01)
            phase_q <= TPG_RUN;
        end
        TPG_RUN:
        begin
          if (stop)
            phase_q <= TPG_IDLE; // [RULE_01]
        end
        default: phase_q <= TPG_IDLE;
      endcase
    end
  end

  // Configuration registers.
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      sel_q <= `TPG_SEL_RST;
      lead_en_q <= 1'b0;
      beats_q <= `TPG_BEATS_RST;
      char_lo_q <= `TPG_CLO_RST;
      char_hi_q <= `TPG_CHI_RST;
    end
    else if (cfg_wr) // [RULE_02]
    begin
      if (idx == `TPG_IDX_SEL)
        sel_q <= pwdata[`TPG_SEL_W-1:0];
      if (idx == `TPG_IDX_LEAD)
      begin
        lead_en_q <= pwdata[`TPG_LEAD_EN_BIT];
        beats_q <= pwdata[`TPG_BEATS_MSB:`TPG_BEATS_LSB]; // [RULE_16]
      end
      if (idx == `TPG_IDX_CLO)
        char_lo_q <= pwdata; // [RULE_17]
      if (idx == `TPG_IDX_CHI)
        char_hi_q <= pwdata[`TPG_CHI_W-1:0]; // [RULE_18]
    end
  end

  // A pending request ignores further writes and clears once applied.
  always_ff @(posedge clk)
  begin
    if (!rst_b)
      inject_q <= 1'b0;
    else if (apply)
      inject_q <= 1'b0; // [RULE_12]
    else if (wr && idx == `TPG_IDX_INJ && pwdata[`TPG_INJ_BIT])
      inject_q <= 1'b1; // [RULE_13]
  end

  // Shift registers restart from all ones on each start.
  always_ff @(posedge clk)
  begin
    if (!rst_b || start)
    begin
      p7_q <= '1;
      p15_q <= '1;
      p23_q <= '1;
      p31_q <= '1;
    end
    else if (phase_q == TPG_RUN)
    begin
      if (sel_q[`TPG_SEL_P7])
        p7_q <= p7_d; // [RULE_04]
      if (sel_q[`TPG_SEL_P15])
        p15_q <= p15_d; // [RULE_05]
      if (sel_q[`TPG_SEL_P23])
        p23_q <= p23_d; // [RULE_06]
      if (sel_q[`TPG_SEL_P31])
        p31_q <= p31_d; // [RULE_07]
    end
  end

  // Stream output; the register simply holds once generation stops, so
  // the final beat stays visible, including a beat whose error was
  // applied in the same cycle that software stops.
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      data_q <= hf_word;
      valid_q <= 1'b0;
    end
    else
    begin
      valid_q <= gen_on; // [RULE_20]
      if (gen_on) // [RULE_03]
        data_q <= beat_d ^ flip; // [RULE_14]
    end
  end

  // Read mux; reserved bits read as zero.
  always_comb
  begin
    rd_d = 32'h00000000;
    case (idx)
      `TPG_IDX_ON: rd_d[`TPG_ON_BIT] = gen_on;
      `TPG_IDX_SEL: rd_d[`TPG_SEL_W-1:0] = sel_q;
      `TPG_IDX_INJ: rd_d[`TPG_INJ_BIT] = inject_q;
      `TPG_IDX_LEAD:
      begin
        rd_d[`TPG_LEAD_EN_BIT] = lead_en_q;
        rd_d[`TPG_BEATS_MSB:`TPG_BEATS_LSB] = beats_q;
      end
      `TPG_IDX_CLO: rd_d = char_lo_q;
      `TPG_IDX_CHI: rd_d[`TPG_CHI_W-1:0] = char_hi_q;
      default: rd_d = 32'h00000000;
    endcase
  end

  // One wait state keeps every bus output registered.
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h00000000;
    end
    else if (psel && penable && !pready_q)
    begin
      pready_q <= 1'b1;
      pslverr_q <= ~mapped;
      prdata_q <= (pwrite || !mapped) ? 32'h00000000 : rd_d;
    end
    else
    begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  sequence lead_start_s;
    start && lead_en_q && beats_q != 8'h00;
  endsequence

  // A request left pending while off lands on the first lead-in beat.
  sequence lead_first_s;
    (lead_cnt_q == $past(beats_q)) ##1
      (data_q == (lead_char ^ {{(stream_width_param-1){1'b0}},
      $past(inject_q)}));
  endsequence

  sequence run_clean_s;
    phase_q == TPG_RUN && !inject_q && !stop;
  endsequence

  valid_follows_a: assert property (gen_on |=> valid_q) // [RULE_20]
    else $error("Stream valid missing while generating.");

  off_no_valid_a: assert property (!gen_on |=> !valid_q) // [RULE_01]
    else $error("Stream valid while generation is off.");

  hold_final_a: assert property ($fell(gen_on) |=> $stable(data_q)[*2]) // [RULE_03]
    else $error("Final beat not held after switch off.");

  frozen_cfg_a: assert property (gen_on && wr && idx != `TPG_IDX_ON // [RULE_02]
    && idx != `TPG_IDX_INJ |=> $stable(sel_q) && $stable(char_lo_q)
    && $stable(beats_q))
    else $error("Configuration changed while generating.");

  inject_flip_a: assert property (apply |=> // [RULE_11]
    $countones(data_q ^ $past(beat_d)) == 1)
    else $error("Error beat does not differ in one bit.");

  inject_clear_a: assert property (inject_q && gen_on |=> !inject_q) // [RULE_12]
    else $error("Error request not cleared when applied.");

  inject_hold_a: assert property (inject_q && !gen_on |=> inject_q) // [RULE_13]
    else $error("Error request lost before it was applied.");

  lead_in_a: assert property (lead_start_s |=> lead_first_s) // [RULE_15]
    else $error("Lead-in character not sent first.");

  prbs7_out_a: assert property (run_clean_s ##0 sel_q == 6'h01 // [RULE_04]
    |=> data_q == $past(p7_bits))
    else $error("PRBS-7 beat wrong.");

  prbs31_out_a: assert property (run_clean_s ##0 sel_q == 6'h08 // [RULE_07]
    |=> data_q == $past(p31_bits))
    else $error("PRBS-31 beat wrong.");

  slow_out_a: assert property (run_clean_s ##0 sel_q == 6'h20 // [RULE_09]
    |=> data_q == lf_word)
    else $error("Low-frequency beat wrong.");

endmodule : tpg_top

`default_nettype wire

// [verif/tpg_sink.sv]
`timescale 1ns/1ps
`default_nettype none

module tpg_sink #(
  parameter int W = 40
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_b,
  // Beats from the generator.
  input wire logic [W-1:0] data,
  input wire logic valid,
  // Observed traffic.
  output logic [15:0] beat_cnt_q
);
  // There is no back-pressure, so every valid beat is taken on arrival.
  always_ff @(posedge clk)
  begin
    if (!rst_b)
      beat_cnt_q <= 16'h0000;
    else if (valid)
      beat_cnt_q <= beat_cnt_q + 16'h0001;
  end
endmodule : tpg_sink

`default_nettype wire

// [verif/testbench.sv]
`include "tpg_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module testbench;
  localparam int W = 40;
  localparam logic [W-1:0] HF = 40'h5555555555;
  localparam logic [W-1:0] LF = {4{10'h3E0}};
  logic clk;
  logic rst_b;
  logic [4:0] paddr;
  logic psel;
  logic penable;
  logic pwrite;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [W-1:0] stream_data;
  logic stream_valid;
  logic [15:0] beat_cnt_q;
  logic [W-1:0] beats [0:7];
  logic [31:0] r;
  logic e;
  int mismatches = 0;
  int check_count = 0;
  int lens [0:3] = '{`TPG_P7_LEN, `TPG_P15_LEN, `TPG_P23_LEN, `TPG_P31_LEN};
  int taps [0:3] = '{`TPG_P7_TAP, `TPG_P15_TAP, `TPG_P23_TAP, `TPG_P31_TAP};

  tpg_top #(.stream_width_param(W)) i_dut (.clk(clk), .rst_b(rst_b),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .stream_data(stream_data), .stream_valid(stream_valid));
  tpg_sink #(.W(W)) i_sink (.clk(clk), .rst_b(rst_b), .data(stream_data),
    .valid(stream_valid), .beat_cnt_q(beat_cnt_q));

  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : end_of_test

  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // The request is held until pready is sampled high at a rising edge.
  task automatic apb(input logic wr, input logic [4:0] a,
    input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20)
    begin
      mismatches++;
      end_of_test();
    end
  endtask : apb

  task automatic wr(input logic [2:0] i, input logic [31:0] d);
    apb(1'b1, {i, 2'b00}, d);
  endtask : wr

  task automatic rd(input logic [2:0] i, input logic [31:0] exp);
    apb(1'b0, {i, 2'b00}, 32'h00000000);
    chk(r, exp);
  endtask : rd

  // Collects n consecutive beats once the stream has started.
  task automatic grab(input int n);
    int k;
    logic [15:0] c0;
    k = 0;
    do
    begin
      @(posedge clk);
      #1;
      k++;
    end
    while (stream_valid !== 1'b1 && k < 20);
    if (k >= 20)
    begin
      mismatches++;
      end_of_test();
    end
    c0 = beat_cnt_q;
    beats[0] = stream_data;
    for (k = 1; k < n; k++)
    begin
      @(posedge clk);
      #1;
      beats[k] = stream_data;
    end
    chk(beat_cnt_q - c0, n - 1);
  endtask : grab

  function automatic int bad_beats(input logic [W-1:0] exp, input int n);
    int c = 0;
    for (int k = 0; k < n; k++)
      c += (beats[k] !== exp);
    return c;
  endfunction : bad_beats

  function automatic int bad_bits(input logic [W-1:0] exp, input int n);
    int c = 0;
    for (int k = 0; k < n; k++)
      c += $countones(beats[k] ^ exp);
    return c;
  endfunction : bad_bits

  // Each serial bit must equal the xor of the bits len and tap places back.
  function automatic int rec_err(input int len, input int tap);
    logic b [0:159];
    int c = 0;
    for (int k = 0; k < 160; k++)
      b[k] = beats[k / W][W - 1 - k % W];
    for (int k = len; k < 160; k++)
      c += (b[k] !== (b[k - len] ^ b[k - tap]));
    return c;
  endfunction : rec_err

  initial
  begin
    rst_b = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 5'h00;
    pwdata = 32'h00000000;
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    #1;
    chk(stream_data, HF);
    rd(`TPG_IDX_SEL, 32'h00000001);
    rd(`TPG_IDX_ON, 32'h00000000);
    apb(1'b0, 5'h18, 32'h00000000);
    chk({e, r}, 33'h100000000);
    wr(`TPG_IDX_CLO, 32'h89ABCDEF);
    wr(`TPG_IDX_CHI, 32'h0000005A);
    wr(`TPG_IDX_LEAD, 32'h00000301);
    rd(`TPG_IDX_CLO, 32'h89ABCDEF);
    rd(`TPG_IDX_CHI, 32'h0000005A);
    rd(`TPG_IDX_LEAD, 32'h00000301);
    $display("test registers done");
    wr(`TPG_IDX_SEL, 32'h00000010);
    wr(`TPG_IDX_ON, 32'h00000001);
    grab(5);
    for (int k = 0; k < 3; k++)
      chk(beats[k], 40'h5A89ABCDEF);
    chk(beats[3], HF);
    wr(`TPG_IDX_SEL, 32'h00000020);
    wr(`TPG_IDX_CLO, 32'h00000000);
    rd(`TPG_IDX_SEL, 32'h00000010);
    rd(`TPG_IDX_CLO, 32'h89ABCDEF);
    rd(`TPG_IDX_ON, 32'h00000001);
    $display("test lead-in done");
    wr(`TPG_IDX_INJ, 32'h00000001);
    grab(8);
    chk(bad_beats(HF, 8), 1);
    chk(bad_bits(HF, 8), 1);
    rd(`TPG_IDX_INJ, 32'h00000000);
    wr(`TPG_IDX_ON, 32'h00000000);
    repeat (4) @(posedge clk);
    #1;
    chk(stream_data, HF);
    chk(stream_valid, 1'b0);
    $display("test inject and stop done");
    wr(`TPG_IDX_LEAD, 32'h00000000);
    wr(`TPG_IDX_INJ, 32'h00000001);
    rd(`TPG_IDX_INJ, 32'h00000001);
    wr(`TPG_IDX_INJ, 32'h00000001);
    wr(`TPG_IDX_SEL, 32'h00000020);
    wr(`TPG_IDX_ON, 32'h00000001);
    grab(8);
    chk(bad_beats(LF, 8), 1);
    chk(bad_bits(LF, 8), 1);
    rd(`TPG_IDX_INJ, 32'h00000000);
    wr(`TPG_IDX_ON, 32'h00000000);
    @(posedge clk);
    #1;
    chk(stream_data, LF);
    $display("test pending inject done");
    for (int k = 0; k < 4; k++)
    begin
      wr(`TPG_IDX_SEL, 32'h00000001 << k);
      wr(`TPG_IDX_ON, 32'h00000001);
      grab(4);
      wr(`TPG_IDX_ON, 32'h00000000);
      chk(rec_err(lens[k], taps[k]), 0);
      chk(bad_beats(40'h0000000000, 4) > 0, 1);
    end
    $display("test prbs done");
    end_of_test();
  end
endmodule : testbench

`default_nettype wire
